// ---- mhi_sequencer.sv ----
// Hood interlock and run sequencer with APB register slave
`timescale 1ns/1ps
module mhi_sequencer #(
	parameter int DEBOUNCE_CYCLES = mhi_pkg::DEBOUNCE_CYC,
	parameter int DELAY_SHORT_CYCLES = mhi_pkg::DELAY_SHORT_CYC,
	parameter int DELAY_LONG_CYCLES = mhi_pkg::DELAY_LONG_CYC,
	parameter int BAUD_FAST_CYCLES = mhi_pkg::BAUD_FAST_DIV,
	parameter int BAUD_SLOW_CYCLES = mhi_pkg::BAUD_SLOW_DIV
) (
	input wire logic sys_clk_i, // System clock, 125 MHz
	input wire logic reset_i, // Asynchronous reset, active high
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [7:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error on unmapped address
	input wire logic estop_active_i, // Emergency-off pressed
	input wire logic drive_btn_i, // Drive-enable button
	input wire logic start_btn_i, // Start button
	input wire logic stop_btn_i, // Stop button
	input wire logic hood_btn_i, // Hood-release button
	input wire logic key_test_i, // Keyswitch in maintenance-open
	input wire logic hood_closed_i, // Hood closed switch
	input wire logic spindle_switch_i, // Spindle rotary switch on
	input wire logic jumper_baud_i, // First option jumper bridged
	input wire logic jumper_delay_i, // Second option jumper bridged
	input wire logic flash_has_prog_i, // Flash holds a program
	input wire logic host_cmd_i, // Host command arrived, pulse
	output logic power_stage_o, // Power stage on
	output logic drive_lamp_o, // Drive-enable lamp
	output logic hood_lamp_o, // Hood-release lamp
	output logic hood_lock_o, // Hood lock engaged
	output logic spindle_on_o, // Spindle current on
	output logic run_o, // Program execution active
	output logic launch_o, // Start program from beginning, pulse
	output logic resume_o, // Resume from held position, pulse
	output logic flash_erase_o, // Erase flash store, pulse
	output logic cmd_accept_o, // Host command accepted, pulse
	output logic cmd_reject_o, // Host command refused, pulse
	output logic baud_slow_o, // Serial link at 9600 baud
	output logic baud_tick_o // One pulse per baud period
);
	logic [mhi_pkg::NUM_IN-1:0] raw_in; // Panel pins
	logic [mhi_pkg::NUM_IN-1:0] sync1, sync2, sync3; // Pin sync chain
	logic [mhi_pkg::NUM_IN-1:0] db_level; // Debounced levels
	logic [mhi_pkg::NUM_IN-1:0] db_prev; // Previous debounced
	logic [mhi_pkg::NUM_IN-1:0] db_rise; // Press pulses
	logic [mhi_pkg::DB_W-1:0] db_cnt [mhi_pkg::NUM_IN]; // Settle counters
	logic [1:0] jmp_s1, jmp_s2, jmp_s3; // Jumper sync chain
	logic [1:0] init_cnt; // Cycles since reset release
	logic cap_done; // Jumpers captured
	logic delay_long; // Five second delay chosen
	logic [mhi_pkg::BD_W-1:0] baud_cnt; // Baud divider
	logic [mhi_pkg::DLY_W-1:0] dly_cnt; // Hood delay counter
	logic delay_done; // Hood delay elapsed
	logic [mhi_pkg::CTRL_W-1:0] ctrl; // Control register
	logic [mhi_pkg::ERR_W-1:0] err; // Sticky error bits
	logic [mhi_pkg::ERR_W-1:0] err_set; // Error events
	logic job_term; // Host terminated the job
	logic hood_unlocked; // Lock released
	logic spindle_block; // Spindle barred after hood opened
	mhi_pkg::mhi_state_type state, next_state; // Sequencer state
	logic apb_wr, apb_rd; // Access-phase write, setup read
	logic addr_ok; // Mapped address
	logic start_ok; // Start conditions met
	logic spindle_ok; // Spindle permitted
	logic lamp_ok; // Hood lamp permitted
	logic delay_restart; // Restart hood delay
	logic [31:0] stat_word; // Status read value
	logic lim_hit; // Delay limit reached

	assign raw_in = {spindle_switch_i, hood_closed_i, key_test_i,
		hood_btn_i, stop_btn_i, start_btn_i, drive_btn_i, estop_active_i};

	// Three flop synchroniser for panel pins
	// sync stage
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Debounce: level accepted once stable for the settle time
	genvar gi;
	generate
		for (gi = 0; gi < mhi_pkg::NUM_IN; gi++) begin : g_db
			always_ff @(posedge sys_clk_i or posedge reset_i) begin
				if (reset_i) begin
					db_cnt[gi] <= '0;
					db_level[gi] <= 1'b0;
				end else if (sync2[gi] != sync3[gi] ||
					sync3[gi] == db_level[gi]) begin
					db_cnt[gi] <= '0;
				end else if (db_cnt[gi] ==
					mhi_pkg::DB_W'(DEBOUNCE_CYCLES - 1)) begin
					db_cnt[gi] <= '0;
					db_level[gi] <= sync3[gi];
				end else begin
					db_cnt[gi] <= db_cnt[gi] + 1'b1;
				end
			end
		end
	endgenerate

	// Edge detect so each press counts once
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			db_prev <= '0;
		end else begin
			db_prev <= db_level;
		end
	end
	assign db_rise = db_level & ~db_prev;

	// Jumper capture, once after reset release
	// power-up sample
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			jmp_s1 <= '0;
			jmp_s2 <= '0;
			jmp_s3 <= '0;
			init_cnt <= '0;
			cap_done <= 1'b0;
			baud_slow_o <= 1'b0;
			delay_long <= 1'b0;
		end else begin
			jmp_s1 <= {jumper_delay_i, jumper_baud_i};
			jmp_s2 <= jmp_s1;
			jmp_s3 <= jmp_s2;
			if (init_cnt != 2'h3) begin
				init_cnt <= init_cnt + 2'h1;
			end else if (!cap_done && jmp_s2 == jmp_s3) begin
				cap_done <= 1'b1;
				baud_slow_o <= jmp_s3[0];
				delay_long <= jmp_s3[1];
			end
		end
	end

	// Baud rate enable divider
	// divider select
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			baud_cnt <= '0;
			baud_tick_o <= 1'b0;
		end else if (baud_cnt == (baud_slow_o ?
			mhi_pkg::BD_W'(BAUD_SLOW_CYCLES - 1) :
			mhi_pkg::BD_W'(BAUD_FAST_CYCLES - 1))) begin
			baud_cnt <= '0;
			baud_tick_o <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 1'b1;
			baud_tick_o <= 1'b0;
		end
	end

	// APB decode, zero wait states
	assign addr_ok = paddr_i == mhi_pkg::REG_CTRL ||
		paddr_i == mhi_pkg::REG_STAT || paddr_i == mhi_pkg::REG_ERR;
	assign pready_o = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	assign apb_wr = psel_i & penable_i & pwrite_i & addr_ok;
	assign apb_rd = psel_i & ~penable_i & ~pwrite_i;

	// Status word from live state
	always_comb begin
		stat_word = '0;
		stat_word[mhi_pkg::ST_STATE_LSB +: 3] = state;
		stat_word[mhi_pkg::ST_POWER] = power_stage_o;
		stat_word[mhi_pkg::ST_LAMP] = hood_lamp_o;
		stat_word[mhi_pkg::ST_LOCK] = hood_lock_o;
		stat_word[mhi_pkg::ST_SPINDLE] = spindle_on_o;
		stat_word[mhi_pkg::ST_BAUD_SLOW] = baud_slow_o;
		stat_word[mhi_pkg::ST_DELAY_LONG] = delay_long;
		stat_word[mhi_pkg::ST_DELAY_DONE] = delay_done;
		stat_word[mhi_pkg::ST_JOB_TERM] = job_term;
	end

	// Read data loaded in the setup cycle
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= '0;
		end else if (apb_rd) begin
			case (paddr_i)
				mhi_pkg::REG_CTRL: prdata_o <= 32'(ctrl);
				mhi_pkg::REG_STAT: prdata_o <= stat_word;
				mhi_pkg::REG_ERR: prdata_o <= 32'(err);
				default: prdata_o <= '0;
			endcase
		end
	end

	// Control register; job-terminate bit is write-only
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= mhi_pkg::CTRL_RESET;
		end else if (apb_wr && paddr_i == mhi_pkg::REG_CTRL) begin
			ctrl <= pwdata_i[mhi_pkg::CTRL_W-1:0];
			ctrl[mhi_pkg::CTRL_JOB_TERM] <= 1'b0;
		end
	end

	// Job termination flag, cleared by the next launch
	// termination memory
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			job_term <= 1'b0;
		end else if (apb_wr && paddr_i == mhi_pkg::REG_CTRL &&
			pwdata_i[mhi_pkg::CTRL_JOB_TERM]) begin
			job_term <= 1'b1;
		end else if (launch_o) begin
			job_term <= 1'b0;
		end
	end

	// Error events
	always_comb begin
		err_set = '0;
		err_set[mhi_pkg::ERR_ESTOP] = db_rise[mhi_pkg::IN_ESTOP];
		err_set[mhi_pkg::ERR_NOPOWER] = host_cmd_i & ~power_stage_o;
		err_set[mhi_pkg::ERR_REJECT] = host_cmd_i & ~cmd_accept_ok();
	end

	// Sticky errors, write one to clear, set wins
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			err <= '0;
		end else if (apb_wr && paddr_i == mhi_pkg::REG_ERR) begin
			err <= (err & ~pwdata_i[mhi_pkg::ERR_W-1:0]) | err_set;
		end else begin
			err <= err | err_set;
		end
	end

	// Command acceptance condition
	function automatic logic cmd_accept_ok();
		return power_stage_o && !(state == mhi_pkg::ST_HOLD &&
			!ctrl[mhi_pkg::CTRL_HOST_MODE]);
	endfunction

	// Host command answer pulses
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cmd_accept_o <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			cmd_accept_o <= host_cmd_i & cmd_accept_ok();
			cmd_reject_o <= host_cmd_i & ~cmd_accept_ok();
		end
	end

	// Start allowed: hood shut and locked, something to run
	// start source
	assign start_ok = db_level[mhi_pkg::IN_HOOD_CLOSED] & ~hood_unlocked &
		(ctrl[mhi_pkg::CTRL_HOST_MODE] | flash_has_prog_i);

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			mhi_pkg::ST_OFF: begin
				if (db_rise[mhi_pkg::IN_DRIVE] &&
					!db_level[mhi_pkg::IN_ESTOP] &&
					!(db_level[mhi_pkg::IN_STOP] &&
					db_level[mhi_pkg::IN_KEY_TEST])) begin
					next_state = mhi_pkg::ST_READY;
				end
			end
			mhi_pkg::ST_READY: begin
				if (db_rise[mhi_pkg::IN_START] && start_ok) begin
					next_state = mhi_pkg::ST_RUN;
				end
			end
			mhi_pkg::ST_RUN: begin
				if (db_rise[mhi_pkg::IN_STOP]) begin
					next_state = mhi_pkg::ST_HOLD;
				end
			end
			mhi_pkg::ST_HOLD: begin
				if (db_rise[mhi_pkg::IN_START] && start_ok) begin
					next_state = mhi_pkg::ST_RUN;
				end
			end
			mhi_pkg::ST_ESTOP: begin
				if (!db_level[mhi_pkg::IN_ESTOP]) begin
					next_state = mhi_pkg::ST_OFF;
				end
			end
			default: next_state = mhi_pkg::ST_OFF;
		endcase
		if (db_level[mhi_pkg::IN_ESTOP]) begin
			next_state = mhi_pkg::ST_ESTOP;
		end
	end

	// State, power stage and run pulses
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= mhi_pkg::ST_OFF;
			power_stage_o <= 1'b0;
			launch_o <= 1'b0;
			resume_o <= 1'b0;
			flash_erase_o <= 1'b0;
		end else begin
			state <= next_state;
			power_stage_o <= next_state == mhi_pkg::ST_READY ||
				next_state == mhi_pkg::ST_RUN ||
				next_state == mhi_pkg::ST_HOLD;
			resume_o <= state == mhi_pkg::ST_HOLD &&
				next_state == mhi_pkg::ST_RUN && !job_term;
			launch_o <= next_state == mhi_pkg::ST_RUN &&
				(state == mhi_pkg::ST_READY ||
				(state == mhi_pkg::ST_HOLD && job_term));
			flash_erase_o <= state == mhi_pkg::ST_OFF &&
				db_rise[mhi_pkg::IN_DRIVE] &&
				!db_level[mhi_pkg::IN_ESTOP] &&
				db_level[mhi_pkg::IN_STOP] &&
				db_level[mhi_pkg::IN_KEY_TEST];
		end
	end
	assign run_o = state == mhi_pkg::ST_RUN;
	assign drive_lamp_o = power_stage_o;

	// Spindle permission; emergency-off and unlock drop it with power
	// spindle gate
	assign spindle_ok = ctrl[mhi_pkg::CTRL_SPINDLE_EN] &
		ctrl[mhi_pkg::CTRL_HOST_CTRL] & power_stage_o & hood_lock_o &
		db_level[mhi_pkg::IN_HOOD_CLOSED] & db_level[mhi_pkg::IN_SPIN_SW] &
		~spindle_block & ~db_level[mhi_pkg::IN_ESTOP] &
		~(db_rise[mhi_pkg::IN_HOOD_BTN] & hood_lamp_o) &
		(state == mhi_pkg::ST_RUN || state == mhi_pkg::ST_READY) &
		~db_rise[mhi_pkg::IN_STOP];

	// Spindle output and block after hood opened
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			spindle_on_o <= 1'b0;
			spindle_block <= 1'b0;
		end else begin
			spindle_on_o <= spindle_ok;
			if (!db_level[mhi_pkg::IN_HOOD_CLOSED]) begin
				spindle_block <= 1'b1;
			end else if (db_rise[mhi_pkg::IN_START]) begin
				spindle_block <= 1'b0;
			end
		end
	end

	// Hood delay from spindle off or end of run
	// delay start
	assign delay_restart = (spindle_on_o & ~spindle_ok) |
		(run_o & next_state != mhi_pkg::ST_RUN);
	assign lim_hit = dly_cnt == (delay_long ?
		mhi_pkg::DLY_W'(DELAY_LONG_CYCLES - 1) :
		mhi_pkg::DLY_W'(DELAY_SHORT_CYCLES - 1));

	// Delay counter; done at reset so the hood opens
	// delay count
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			dly_cnt <= '0;
			delay_done <= 1'b1;
		end else if (delay_restart) begin
			dly_cnt <= '0;
			delay_done <= 1'b0;
		end else if (!delay_done) begin
			dly_cnt <= dly_cnt + 1'b1;
			delay_done <= lim_hit;
		end
	end

	// Lamp: still, spindle off, software allows or emergency-off state
	// lamp gate
	assign lamp_ok = delay_done & ~spindle_ok & ~spindle_on_o &
		((ctrl[mhi_pkg::CTRL_HOOD_EN] &
		(~run_o | db_level[mhi_pkg::IN_KEY_TEST])) |
		state == mhi_pkg::ST_ESTOP);

	// Lamp and lock
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hood_lamp_o <= 1'b0;
			hood_unlocked <= 1'b0;
		end else begin
			hood_lamp_o <= lamp_ok;
			if (db_rise[mhi_pkg::IN_HOOD_BTN] && hood_lamp_o) begin
				hood_unlocked <= 1'b1;
			end else if (db_rise[mhi_pkg::IN_HOOD_CLOSED]) begin
				hood_unlocked <= 1'b0;
			end
		end
	end
	assign hood_lock_o = ~hood_unlocked;

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_spindle_gate;
		spindle_on_o |-> power_stage_o && hood_lock_o &&
			$past(ctrl[mhi_pkg::CTRL_SPINDLE_EN]);
	endproperty
	a_spindle_gate: assert property (p_spindle_gate)
		else $error("spindle on without permission");

	property p_drive_lamp;
		drive_lamp_o == (state == mhi_pkg::ST_READY ||
			state == mhi_pkg::ST_RUN || state == mhi_pkg::ST_HOLD);
	endproperty
	a_drive_lamp: assert property (p_drive_lamp)
		else $error("drive lamp differs from power stage state");

	property p_estop;
		db_level[mhi_pkg::IN_ESTOP] |=> state == mhi_pkg::ST_ESTOP &&
			!power_stage_o ##1 !spindle_on_o;
	endproperty
	a_estop: assert property (p_estop)
		else $error("emergency-off did not abort");

	property p_drive_needs_release;
		$rose(power_stage_o) |-> $past(!db_level[mhi_pkg::IN_ESTOP]);
	endproperty
	a_drive_needs_release: assert property (p_drive_needs_release)
		else $error("power stage on during emergency-off");

	property p_stop_hold;
		run_o && db_rise[mhi_pkg::IN_STOP] && !db_level[mhi_pkg::IN_ESTOP]
			|=> state == mhi_pkg::ST_HOLD && !spindle_on_o;
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("stop did not hold and stop spindle");

	property p_unlock_lit;
		$rose(hood_unlocked) |-> $past(hood_lamp_o);
	endproperty
	a_unlock_lit: assert property (p_unlock_lit)
		else $error("hood unlocked while lamp dark");

	property p_lamp_safe;
		hood_lamp_o |-> $past(delay_done) && $past(!spindle_on_o);
	endproperty
	a_lamp_safe: assert property (p_lamp_safe)
		else $error("hood lamp lit before delay or with spindle");

	property p_nopower_err;
		host_cmd_i && !power_stage_o |=> err[mhi_pkg::ERR_NOPOWER];
	endproperty
	a_nopower_err: assert property (p_nopower_err)
		else $error("command without power not flagged");

	property p_jumper_hold;
		cap_done && $past(cap_done) |-> $stable(baud_slow_o) &&
			$stable(delay_long);
	endproperty
	a_jumper_hold: assert property (p_jumper_hold)
		else $error("jumper choice changed after power-up");

	property p_erase;
		flash_erase_o |-> $past(state == mhi_pkg::ST_OFF) &&
			$past(db_level[mhi_pkg::IN_STOP]) && !power_stage_o;
	endproperty
	a_erase: assert property (p_erase)
		else $error("flash erase outside its combination");

	property p_standalone_reject;
		host_cmd_i && state == mhi_pkg::ST_HOLD &&
			!ctrl[mhi_pkg::CTRL_HOST_MODE] |=> cmd_reject_o && !cmd_accept_o;
	endproperty
	a_standalone_reject: assert property (p_standalone_reject)
		else $error("standalone hold accepted a command");

	c_resume: cover property (state == mhi_pkg::ST_HOLD ##1 resume_o);
	c_launch: cover property (launch_o);
	c_unlock: cover property ($rose(hood_unlocked));
	c_erase: cover property (flash_erase_o);
endmodule

// ---- mhi_pkg.sv ----
// Constants, register map and state type of the hood interlock sequencer
package mhi_pkg;
	// Clock rate and printed times
	localparam int CLK_HZ = 125_000_000;
	localparam int DELAY_SHORT_S = 1;
	localparam int DELAY_LONG_S = 5;
	localparam int DELAY_SHORT_CYC = CLK_HZ * DELAY_SHORT_S;
	localparam int DELAY_LONG_CYC = CLK_HZ * DELAY_LONG_S;
	localparam int BAUD_FAST = 19200;
	localparam int BAUD_SLOW = 9600;
	localparam int BAUD_FAST_DIV = CLK_HZ / BAUD_FAST;
	localparam int BAUD_SLOW_DIV = CLK_HZ / BAUD_SLOW;
	localparam int DEBOUNCE_US = 10000;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	// Counter widths
	localparam int DLY_W = 30;
	localparam int DB_W = 21;
	localparam int BD_W = 14;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_ERR = 8'h08;
	// Control register fields
	localparam int CTRL_SPINDLE_EN = 0;
	localparam int CTRL_HOST_CTRL = 1;
	localparam int CTRL_HOOD_EN = 2;
	localparam int CTRL_JOB_TERM = 3;
	localparam int CTRL_HOST_MODE = 4;
	localparam int CTRL_W = 5;
	localparam logic [4:0] CTRL_RESET = 5'h04;
	// Error register fields
	localparam int ERR_ESTOP = 0;
	localparam int ERR_NOPOWER = 1;
	localparam int ERR_REJECT = 2;
	localparam int ERR_W = 3;
	// Status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_POWER = 3;
	localparam int ST_LAMP = 4;
	localparam int ST_LOCK = 5;
	localparam int ST_SPINDLE = 6;
	localparam int ST_BAUD_SLOW = 7;
	localparam int ST_DELAY_LONG = 8;
	localparam int ST_DELAY_DONE = 9;
	localparam int ST_JOB_TERM = 10;
	// Debounced input indices
	localparam int IN_ESTOP = 0;
	localparam int IN_DRIVE = 1;
	localparam int IN_START = 2;
	localparam int IN_STOP = 3;
	localparam int IN_HOOD_BTN = 4;
	localparam int IN_KEY_TEST = 5;
	localparam int IN_HOOD_CLOSED = 6;
	localparam int IN_SPIN_SW = 7;
	localparam int NUM_IN = 8;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_READY = 3'b001,
		ST_RUN = 3'b010,
		ST_HOLD = 3'b011,
		ST_ESTOP = 3'b100
	} mhi_state_type;
endpackage

// ---- mhi_panel_model.sv ----
// Operator panel and host command source for the sequencer bench
`timescale 1ns/1ps
module mhi_panel_model (
	input wire logic clk_i, // Bench clock
	output logic [7:0] pins_o, // Panel levels by input index
	output logic host_cmd_o // Host command pulse
);
	logic [7:0] lv = 8'h40; // Levels, hood closed at start
	logic cmd = 1'h0; // Command strobe
	assign pins_o = lv;
	assign host_cmd_o = cmd;
	// Change one level, then hold it past the debounce span
	task set_pin(input int idx, input logic val);
		@(posedge clk_i);
		lv[idx] <= val;
		repeat (10) @(posedge clk_i);
		#1;
	endtask
	// Press and release one button
	task press(input int idx);
		set_pin(idx, 1'h1);
		set_pin(idx, 1'h0);
	endtask
	// One-cycle command pulse from the host
	task send_cmd();
		@(posedge clk_i);
		cmd <= 1'h1;
		@(posedge clk_i);
		cmd <= 1'h0;
		#1;
	endtask
endmodule

// ---- mhi_sequencer_tb.sv ----
// Self-checking bench for the hood interlock sequencer
`timescale 1ns/1ps
module mhi_sequencer_tb;
	logic sys_clk = 1'h0; // 125 MHz clock
	logic reset = 1'h1; // Block reset
	logic psel = 1'h0; // APB select
	logic penable = 1'h0; // APB enable
	logic pwrite = 1'h0; // APB direction
	logic [7:0] paddr = 8'h00; // APB address
	logic [31:0] pwdata = 32'h0; // APB write data
	logic [31:0] prdata, rd; // Read bus and last read word
	logic pready, pslverr, err; // APB answer and last error
	logic jb = 1'h0; // Baud jumper
	logic jd = 1'h0; // Delay jumper
	logic flash = 1'h1; // Stored program present
	logic [7:0] pins; // Panel levels
	logic hcmd; // Host command pulse
	logic power, dlamp, lamp, lock, spin, run, slow, tick; // Levels
	logic [4:0] pl; // Pulse outputs, counted below
	logic launch, resume, erase, acc, rej; // Pulse outputs by name
	logic estop_pin, drive_pin, start_pin, stop_pin; // Panel buttons
	logic hbtn_pin, key_pin, closed_pin, spsw_pin; // Panel switches
	localparam int DLY_S = 20; // Short hood delay in sim
	localparam int DLY_L = 50; // Long hood delay in sim
	int cnt [5] = '{default: 0}; // Pulse counts
	int n_mismatch = 0; // Mismatch count
	int n_checks = 0; // Comparison count
	int i; // Loop index
	mhi_sequencer #(.DEBOUNCE_CYCLES(4), .DELAY_SHORT_CYCLES(DLY_S),
		.DELAY_LONG_CYCLES(DLY_L), .BAUD_FAST_CYCLES(8),
		.BAUD_SLOW_CYCLES(16)) uut (
		.sys_clk_i(sys_clk), .reset_i(reset), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .estop_active_i(estop_pin),
		.drive_btn_i(drive_pin), .start_btn_i(start_pin),
		.stop_btn_i(stop_pin), .hood_btn_i(hbtn_pin),
		.key_test_i(key_pin), .hood_closed_i(closed_pin),
		.spindle_switch_i(spsw_pin), .jumper_baud_i(jb),
		.jumper_delay_i(jd), .flash_has_prog_i(flash),
		.host_cmd_i(hcmd), .power_stage_o(power),
		.drive_lamp_o(dlamp), .hood_lamp_o(lamp), .hood_lock_o(lock),
		.spindle_on_o(spin), .run_o(run), .launch_o(launch),
		.resume_o(resume), .flash_erase_o(erase),
		.cmd_accept_o(acc), .cmd_reject_o(rej),
		.baud_slow_o(slow), .baud_tick_o(tick));
	mhi_panel_model panel (.clk_i(sys_clk), .pins_o(pins),
		.host_cmd_o(hcmd));
	// Panel levels split out by input index, pulses gathered
	assign {spsw_pin, closed_pin, key_pin, hbtn_pin, stop_pin, start_pin,
		drive_pin, estop_pin} = pins;
	assign pl = {rej, acc, erase, resume, launch};
	// Free-running clock
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// Count every one-cycle pulse
	always @(posedge sys_clk) begin
		for (int k = 0; k < 5; k++) cnt[k] <= cnt[k] + pl[k];
	end
	// Compare and report
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	// One clock, then let outputs settle
	task step();
		@(posedge sys_clk);
		#1;
	endtask
	// One APB transfer, waiting for ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask
	// Register read
	task rdreg(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
	endtask
	// Reset held for ten clocks
	task do_reset();
		@(posedge sys_clk);
		reset <= 1'h1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (10) step();
	endtask
	// Cycles between two baud ticks
	task baud_period(input int exp);
		int n;
		n = 0;
		for (i = 0; i < 40 && tick !== 1'h1; i++) step();
		for (i = 0; i < 40 && (n == 0 || tick !== 1'h1); i++) begin
			step();
			n++;
		end
		chk(n, exp);
	endtask
	// Wait a bounded time for the hood lamp, counting the cycles
	task wait_lamp(input int exp);
		for (i = 0; i < 80 && lamp !== 1'h1; i++) step();
		chk(lamp, 1'h1);
		chk(i, exp);
	endtask
	// Power-up defaults and unmapped access
	task t_boot();
		chk(lamp, 1'h1);
		chk(lock, 1'h1);
		chk(slow, 1'h0);
		baud_period(8);
		rdreg(8'h04);
		chk(rd[8], 1'h0);
		rdreg(8'h0C);
		chk(err, 1'h1);
		chk(rd, 32'h0);
		$display("boot test done");
	endtask
	// Command without power, drive refused under emergency-off
	task t_power();
		panel.send_cmd();
		rdreg(8'h08);
		chk(rd[1], 1'h1);
		panel.set_pin(0, 1'h1);
		panel.press(1);
		chk(power, 1'h0);
		panel.set_pin(0, 1'h0);
		apb(1'h1, 8'h08, 32'h7);
		panel.press(1);
		chk(power, 1'h1);
		chk(dlamp, 1'h1);
		$display("power test done");
	endtask
	// Launch stored program, spindle gating, dark lamp ignored
	task t_run();
		apb(1'h1, 8'h00, 32'h6);
		panel.set_pin(7, 1'h1);
		chk(spin, 1'h0);
		apb(1'h1, 8'h00, 32'h7);
		panel.press(2);
		chk(cnt[0], 32'h1);
		chk(run, 1'h1);
		chk(spin, 1'h1);
		chk(lamp, 1'h0);
		panel.press(4);
		chk(lock, 1'h1);
		$display("run test done");
	endtask
	// Stop, release delay, command handling in hold
	task t_stop();
		panel.press(3);
		chk(run, 1'h0);
		chk(spin, 1'h0);
		chk(lamp, 1'h0);
		wait_lamp(DLY_S - 12);
		panel.send_cmd();
		rdreg(8'h08);
		chk(rd[2], 1'h1);
		chk(cnt[4], 32'h2);
		chk(cnt[3], 32'h0);
		apb(1'h1, 8'h00, 32'h17);
		panel.send_cmd();
		step();
		chk(cnt[3], 32'h1);
		$display("stop test done");
	endtask
	// Hood open, relock on closing, resume by start
	task t_hood();
		panel.press(4);
		chk(lock, 1'h0);
		panel.set_pin(6, 1'h0);
		panel.set_pin(6, 1'h1);
		chk(lock, 1'h1);
		chk(run, 1'h0);
		panel.press(2);
		chk(cnt[1], 32'h1);
		chk(run, 1'h1);
		panel.press(3);
		apb(1'h1, 8'h00, 32'h1F);
		rdreg(8'h04);
		chk(rd[10], 1'h1);
		panel.press(2);
		chk(cnt[0], 32'h2);
		chk(cnt[1], 32'h1);
		chk(run, 1'h1);
		$display("hood test done");
	endtask
	// Emergency-off in mid-run
	task t_estop();
		panel.set_pin(0, 1'h1);
		chk(run, 1'h0);
		chk(power, 1'h0);
		rdreg(8'h08);
		chk(rd[0], 1'h1);
		wait_lamp(DLY_S - 4);
		panel.set_pin(0, 1'h0);
		$display("estop test done");
	endtask
	// Jumpers bridged, sampled only at power-up, then erase
	task t_jumper();
		@(posedge sys_clk);
		jb <= 1'h1;
		jd <= 1'h1;
		do_reset();
		chk(slow, 1'h1);
		baud_period(16);
		rdreg(8'h04);
		chk(rd[8], 1'h1);
		@(posedge sys_clk);
		jb <= 1'h0;
		repeat (10) step();
		chk(slow, 1'h1);
		panel.set_pin(5, 1'h1);
		panel.set_pin(3, 1'h1);
		panel.press(1);
		panel.set_pin(3, 1'h0);
		chk(cnt[2], 32'h1);
		chk(power, 1'h0);
		panel.press(1);
		chk(power, 1'h1);
		@(posedge sys_clk);
		flash <= 1'h0;
		panel.press(2);
		chk(run, 1'h0);
		@(posedge sys_clk);
		flash <= 1'h1;
		panel.press(2);
		chk(run, 1'h1);
		chk(cnt[0], 32'h3);
		chk(lamp, 1'h1);
		panel.set_pin(0, 1'h1);
		wait_lamp(DLY_L - 1);
		$display("jumper test done");
	endtask
	// Verdict and end of run
	task conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		conclude();
	end
	// Main sequence
	initial begin
		do_reset();
		t_boot();
		t_power();
		t_run();
		t_stop();
		t_hood();
		t_estop();
		t_jumper();
		conclude();
	end
endmodule
